// ### design/nv_settings.sv
// nonvolatile settings store: three fields, registered read data
`timescale 1ns/1ns
`include "pir_settings_map.svh"
module nv_settings
    import pir_settings_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        wr_sens_in,
    input  wire logic        wr_dwell_in,
    input  wire logic        wr_mode_in,
    input  wire logic        wr_defaults_in,
    input  wire sens_t       sens_in,
    input  wire logic [3:0]  dwell_in,
    input  wire mode_t       mode_in,
    output sens_t            sens_out,
    output logic [3:0]       dwell_out,
    output mode_t            mode_out
);
    // ======================================================================
    // storage cells: deliberately outside the logic reset so they outlive it
    sens_t       cell_sens  = SENS_MED;
    logic [3:0]  cell_dwell = `DWELL_DEFAULT;
    mode_t       cell_mode  = MODE_RETRIG;
    sens_t       rd_sens    = SENS_MED;
    logic [3:0]  rd_dwell   = `DWELL_DEFAULT;
    mode_t       rd_mode    = MODE_RETRIG;

    // each field has its own write strobe; untouched fields hold
    always_ff @(posedge clk_in) begin
        if (wr_defaults_in) begin
            cell_sens  <= SENS_MED;
            cell_dwell <= `DWELL_DEFAULT;
            cell_mode  <= MODE_RETRIG;
        end else begin
            if (wr_sens_in) begin
                cell_sens <= sens_in;
            end
            if (wr_dwell_in) begin
                cell_dwell <= dwell_in;
            end
            if (wr_mode_in) begin
                cell_mode <= mode_in;
            end
        end
    end

    // read register
    always_ff @(posedge clk_in) begin
        rd_sens  <= cell_sens;
        rd_dwell <= cell_dwell;
        rd_mode  <= cell_mode;
    end

    assign sens_out  = rd_sens;
    assign dwell_out = rd_dwell;
    assign mode_out  = rd_mode;
endmodule

// ### design/pir_setting_program_output.sv
// pad programming, settings commit and detect output timing
`timescale 1ns/1ns
`include "pir_settings_map.svh"
module pir_setting_program_output
    import pir_settings_pkg::*;
#(
    parameter int MS_CYCLES = `MS_CYCLES
) (
    input  wire logic   clk_in,
    input  wire logic   rst_in,
    input  wire logic   select_pad_a_n_in,
    input  wire logic   select_pad_b_n_in,
    input  wire logic   store_pad_n_in,
    input  wire level_t level_pad_in,
    input  wire logic   motion_in,
    input  wire logic   motion_left_in,
    input  wire logic   motion_right_in,
    output logic        detect_out,
    output sens_t       sens_level_out,
    output logic [3:0]  dwell_sel_out,
    output mode_t       mode_out
);
    // ======================================================================
    // millisecond tick keeps the long timers narrow
    logic [31:0] ms_div;
    logic        ms_tick;
    always_ff @(posedge clk_in) begin
        ms_div <= (rst_in || ms_div == 32'(MS_CYCLES - 1)) ? 32'h0 : ms_div + 32'h1;
    end
    always_ff @(posedge clk_in) begin
        ms_tick <= !rst_in && ms_div == 32'(MS_CYCLES - 1);
    end

    // ======================================================================
    // pad synchronise and debounce, index 0 a, 1 b, 2 store (1 = grounded)
    logic [2:0] pad_raw;
    logic [2:0] pad_low;
    assign pad_raw = {!store_pad_n_in, !select_pad_b_n_in, !select_pad_a_n_in};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_pad
            logic        sync1;
            logic        sync2;
            logic        stable;
            logic [19:0] dcnt;
            // two flops, then a level must hold for the debounce time
            always_ff @(posedge clk_in) begin
                sync1 <= pad_raw[gi];
                sync2 <= sync1;
            end
            always_ff @(posedge clk_in) begin
                if (rst_in) begin
                    stable <= 1'b0;
                    dcnt   <= 20'h0;
                end else if (sync2 == stable) begin
                    dcnt <= 20'h0;
                end else if (ms_tick) begin
                    if (dcnt == `DEBOUNCE_MS - 20'h1) begin
                        stable <= sync2;
                        dcnt   <= 20'h0;
                    end else begin
                        dcnt <= dcnt + 20'h1;
                    end
                end
            end
            assign pad_low[gi] = stable;
        end
    endgenerate

    // ======================================================================
    // store hold timer; armed only after a full second of ground
    logic [19:0] hold_ms;
    logic        hold_done;
    logic        store_prev;
    always_ff @(posedge clk_in) begin
        if (rst_in || !pad_low[2]) begin
            hold_ms   <= 20'h0;
            hold_done <= 1'b0;
        end else if (ms_tick && !hold_done) begin
            hold_ms <= hold_ms + 20'h1;
            if (hold_ms == `STORE_HOLD_MS - 20'h1) begin
                hold_done <= 1'b1;
            end
        end
    end
    always_ff @(posedge clk_in) begin
        store_prev <= rst_in ? 1'b0 : pad_low[2];
    end

    // ======================================================================
    // decode the pads into a field write at the moment of release
    logic        commit;
    logic        wr_sens;
    logic        wr_dwell;
    logic        wr_mode;
    logic        wr_defaults;
    sens_t       wr_sens_val;
    logic [3:0]  wr_dwell_val;
    mode_t       wr_mode_val;
    assign commit = store_prev && !pad_low[2] && hold_done;
    always_ff @(posedge clk_in) begin
        wr_sens     <= 1'b0;
        wr_dwell    <= 1'b0;
        wr_mode     <= 1'b0;
        wr_defaults <= 1'b0;
        if (!rst_in && commit) begin
            case (pad_low[1:0])
                2'b00:   wr_sens  <= 1'b1;
                2'b01:   wr_dwell <= 1'b1;
                2'b10:   wr_dwell <= 1'b1;
                default: begin
                    wr_defaults <= level_pad_in == LVL_GND;
                    wr_mode     <= level_pad_in != LVL_GND;
                end
            endcase
        end
    end
    // value tables; the level code arrives pre-classified
    always_ff @(posedge clk_in) begin
        case (level_pad_in)
            LVL_2K7: wr_sens_val <= SENS_MIN;
            LVL_6K8: wr_sens_val <= SENS_LOW;
            LVL_15K: wr_sens_val <= SENS_HIGH;
            LVL_39K: wr_sens_val <= SENS_MAX;
            default: wr_sens_val <= SENS_MED;
        endcase
        case ({pad_low[1], level_pad_in})
            {1'b0, LVL_2K7}: wr_dwell_val <= `DWELL_IDX_0S3;
            {1'b0, LVL_6K8}: wr_dwell_val <= `DWELL_IDX_2S;
            {1'b0, LVL_15K}: wr_dwell_val <= `DWELL_IDX_5S;
            {1'b0, LVL_39K}: wr_dwell_val <= `DWELL_IDX_10S;
            {1'b1, LVL_GND}: wr_dwell_val <= `DWELL_IDX_30S;
            {1'b1, LVL_2K7}: wr_dwell_val <= `DWELL_IDX_1M;
            {1'b1, LVL_6K8}: wr_dwell_val <= `DWELL_IDX_2M;
            {1'b1, LVL_15K}: wr_dwell_val <= `DWELL_IDX_5M;
            {1'b1, LVL_39K}: wr_dwell_val <= `DWELL_IDX_10M;
            default:         wr_dwell_val <= `DWELL_IDX_1S;
        endcase
        case (level_pad_in)
            LVL_6K8: wr_mode_val <= MODE_SINGLE;
            LVL_15K: wr_mode_val <= MODE_LEFT;
            LVL_39K: wr_mode_val <= MODE_RIGHT;
            default: wr_mode_val <= MODE_RETRIG;
        endcase
    end

    // store itself is untouched by the logic reset
    nv_settings u_store (
        .clk_in         (clk_in),
        .wr_sens_in     (wr_sens),
        .wr_dwell_in    (wr_dwell),
        .wr_mode_in     (wr_mode),
        .wr_defaults_in (wr_defaults),
        .sens_in        (wr_sens_val),
        .dwell_in       (wr_dwell_val),
        .mode_in        (wr_mode_val),
        .sens_out       (sens_level_out),
        .dwell_out      (dwell_sel_out),
        .mode_out       (mode_out)
    );

    // ======================================================================
    // output timing state machine
    function automatic logic [19:0] dwell_ms(input logic [3:0] idx);
        case (idx)
            4'h0:    dwell_ms = `DWELL_MS_0;
            4'h1:    dwell_ms = `DWELL_MS_1;
            4'h2:    dwell_ms = `DWELL_MS_2;
            4'h3:    dwell_ms = `DWELL_MS_3;
            4'h4:    dwell_ms = `DWELL_MS_4;
            4'h5:    dwell_ms = `DWELL_MS_5;
            4'h6:    dwell_ms = `DWELL_MS_6;
            4'h7:    dwell_ms = `DWELL_MS_7;
            4'h8:    dwell_ms = `DWELL_MS_8;
            default: dwell_ms = `DWELL_MS_9;
        endcase
    endfunction

    out_state_t  state;
    out_state_t  next_state;
    logic [19:0] timer;
    logic [19:0] on_ms;
    logic        trig;
    logic        any_motion;
    logic        expire;
    logic        retrig;
    assign any_motion = motion_in || motion_left_in || motion_right_in;
    assign expire     = ms_tick && timer == on_ms - 20'h1;
    // direction modes only see their own direction
    always_comb begin
        case (mode_out)
            MODE_LEFT:  trig = motion_left_in;
            MODE_RIGHT: trig = motion_right_in;
            default:    trig = motion_in;
        endcase
    end
    // shortest dwell is excluded from retriggering
    assign retrig = mode_out == MODE_RETRIG && dwell_sel_out != `DWELL_IDX_0S3
                    && motion_in;

    always_comb begin
        next_state = state;
        case (state)
            OUT_IDLE: begin
                if (trig) begin
                    next_state = OUT_ON;
                end
            end
            OUT_ON: begin
                if (expire && !retrig) begin
                    next_state = mode_out == MODE_RETRIG ? OUT_IDLE : OUT_QUIET;
                end
            end
            OUT_QUIET: begin
                if (ms_tick && !any_motion && timer == `QUIET_MS - 20'h1) begin
                    next_state = OUT_IDLE;
                end
            end
            default: next_state = OUT_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        state <= rst_in ? OUT_IDLE : next_state;
    end
    // one timer serves the on time and the quiet gap
    always_ff @(posedge clk_in) begin
        if (rst_in || next_state != state) begin
            timer <= 20'h0;
        end else if (state == OUT_ON && retrig) begin
            timer <= 20'h0;
        end else if (state == OUT_QUIET && any_motion) begin
            timer <= 20'h0;
        end else if (ms_tick) begin
            timer <= timer + 20'h1;
        end
    end
    // on time latched at the trigger, fixed for direction pulses
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            on_ms <= `DWELL_MS_1;
        end else if (state == OUT_IDLE && trig) begin
            if (mode_out == MODE_LEFT || mode_out == MODE_RIGHT) begin
                on_ms <= `DIR_PULSE_MS;
            end else begin
                on_ms <= dwell_ms(dwell_sel_out);
            end
        end
    end
    // output high exactly while on
    always_ff @(posedge clk_in) begin
        detect_out <= !rst_in && next_state == OUT_ON;
    end

    // ======================================================================
    // checks
    chk_out_tracks_state: assert property (@(posedge clk_in) disable iff (rst_in)
        detect_out == (state == OUT_ON))
        else $error("detect output disagrees with on state");
    chk_store_after_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        (wr_sens || wr_dwell || wr_mode || wr_defaults) |-> $past(hold_done, 2))
        else $error("write without a full store hold");
    chk_store_on_release: assert property (@(posedge clk_in) disable iff (rst_in)
        (store_prev && !pad_low[2] && hold_done) |=> (wr_sens || wr_dwell || wr_mode
        || wr_defaults))
        else $error("release after hold did not write");
    chk_nv_stable: assert property (@(posedge clk_in) disable iff (rst_in)
        (!wr_sens && !wr_defaults)[*2] |=> $stable(sens_level_out))
        else $error("sensitivity changed without a store");
    chk_field_isolation: assert property (@(posedge clk_in) disable iff (rst_in)
        (wr_sens && !wr_mode && !wr_dwell) |=> ##1 $stable(mode_out) && $stable(dwell_sel_out))
        else $error("sensitivity store touched another field");
    chk_defaults_all: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_defaults |-> ##2 sens_level_out == SENS_MED && dwell_sel_out == `DWELL_DEFAULT
        && mode_out == MODE_RETRIG)
        else $error("restore did not reach all defaults");
    chk_sens_min_code: assert property (@(posedge clk_in) disable iff (rst_in)
        commit && pad_low[1:0] == 2'b00 && level_pad_in == LVL_2K7 |-> ##3
        sens_level_out == SENS_MIN)
        else $error("2.7k level did not give minimum sensitivity");
    chk_retrig_restart: assert property (@(posedge clk_in) disable iff (rst_in)
        state == OUT_ON && retrig && next_state == OUT_ON |=> timer == 20'h0)
        else $error("retrigger did not restart the dwell timer");
    chk_dir_fixed_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
        state == OUT_IDLE && trig && (mode_out == MODE_LEFT || mode_out == MODE_RIGHT)
        |=> on_ms == `DIR_PULSE_MS && detect_out)
        else $error("direction pulse length is not fixed");
    chk_single_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
        state == OUT_ON && next_state != OUT_ON && mode_out == MODE_SINGLE
        |=> state == OUT_QUIET && !detect_out)
        else $error("single pulse skipped the quiet gap");
    cov_retrig: cover property (@(posedge clk_in) disable iff (rst_in)
        state == OUT_ON && retrig);
    cov_quiet_exit: cover property (@(posedge clk_in) disable iff (rst_in)
        state == OUT_QUIET && next_state == OUT_IDLE);
    cov_defaults: cover property (@(posedge clk_in) disable iff (rst_in) wr_defaults);
    cov_dwell_write: cover property (@(posedge clk_in) disable iff (rst_in) wr_dwell);
endmodule

// ### design/pir_settings_map.svh
// constants for the motion detector settings store and output stage
// ==========================================================================
// Overview of operation
// - detect output is low without motion and goes high for one on time when motion is reported.
// - store commits only after the store pad is grounded one second then released.
// - stored settings stay until overwritten and survive power removal.
// - sensitivity, dwell and mode are separate; a store updates only the selected one.
// - both selects and level grounded at store restores all three defaults.
// - both selects open: level code sets one of five sensitivities.
// - select a grounded only: level code sets dwell 0.3, 1, 2, 5 or 10 s.
// - select b grounded only: level code sets dwell 30 s up to 10 min.
// - both selects grounded: level code sets one of four output modes.
// - five sensitivity levels, ten dwell times, four output modes.
// - unprogrammed part runs retriggerable, one second dwell, medium sensitivity.
// - retriggerable mode restarts the dwell timer on motion while on.
// - shortest dwell never retriggers.
// - single pulse lasts one dwell, then needs a quiet gap before rearming.
// - direction modes give a fixed 200 ms pulse for the chosen direction only.
`ifndef PIR_SETTINGS_MAP_SVH
`define PIR_SETTINGS_MAP_SVH

// ==========================================================================
// timing
`define CLK_PERIOD_NS   4
`define NS_PER_MS       1000000
`define MS_CYCLES       ((`NS_PER_MS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STORE_HOLD_MS   20'd1000
`define DEBOUNCE_MS     20'd20
`define QUIET_MS        20'd1000
`define DIR_PULSE_MS    20'd200

// ==========================================================================
// dwell durations in ms, by dwell index
`define DWELL_MS_0      20'd300
`define DWELL_MS_1      20'd1000
`define DWELL_MS_2      20'd2000
`define DWELL_MS_3      20'd5000
`define DWELL_MS_4      20'd10000
`define DWELL_MS_5      20'd30000
`define DWELL_MS_6      20'd60000
`define DWELL_MS_7      20'd120000
`define DWELL_MS_8      20'd300000
`define DWELL_MS_9      20'd600000

// ==========================================================================
// dwell indices and reset values
`define DWELL_IDX_0S3   4'h0
`define DWELL_IDX_1S    4'h1
`define DWELL_IDX_2S    4'h2
`define DWELL_IDX_5S    4'h3
`define DWELL_IDX_10S   4'h4
`define DWELL_IDX_30S   4'h5
`define DWELL_IDX_1M    4'h6
`define DWELL_IDX_2M    4'h7
`define DWELL_IDX_5M    4'h8
`define DWELL_IDX_10M   4'h9
`define DWELL_DEFAULT   `DWELL_IDX_1S

`endif

// ### design/pir_settings_pkg.sv
// types shared by the motion detector settings store and output stage
package pir_settings_pkg;

    // resistor class seen on the level pad
    typedef enum logic [2:0] {
        LVL_GND,
        LVL_2K7,
        LVL_6K8,
        LVL_15K,
        LVL_39K
    } level_t;

    typedef enum logic [2:0] {
        SENS_MIN,
        SENS_LOW,
        SENS_MED,
        SENS_HIGH,
        SENS_MAX
    } sens_t;

    typedef enum logic [1:0] {
        MODE_RETRIG,
        MODE_SINGLE,
        MODE_LEFT,
        MODE_RIGHT
    } mode_t;

    typedef enum logic [1:0] {
        OUT_IDLE,
        OUT_ON,
        OUT_QUIET
    } out_state_t;

endpackage

// ### tb/pad_operator.sv
// pad operator and sensor stand-in driving the programming pads and motion lines
`timescale 1ns/1ns
module pad_operator
    import pir_settings_pkg::*;
#(
    parameter int MS_CYCLES = 10
) (
    input  wire logic clk_in,
    output logic      select_pad_a_n_out,
    output logic      select_pad_b_n_out,
    output logic      store_pad_n_out,
    output level_t    level_pad_out,
    output logic      motion_out,
    output logic      motion_left_out,
    output logic      motion_right_out
);
    // ======================================================================
    // idle: pads open; the pulled-up level pad reads as the highest class
    initial begin
        select_pad_a_n_out = 1'h1;
        select_pad_b_n_out = 1'h1;
        store_pad_n_out    = 1'h1;
        level_pad_out      = LVL_39K;
        motion_out         = 1'h0;
        motion_left_out    = 1'h0;
        motion_right_out   = 1'h0;
    end

    // every change lands a fixed 1 ns after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // selects and level first, store grounded then opened, pads removed last
    task automatic store(input logic a_n, input logic b_n, input level_t lvl, input int hold_ms);
        select_pad_a_n_out = a_n;
        select_pad_b_n_out = b_n;
        level_pad_out = lvl;
        tick(5 * MS_CYCLES);
        store_pad_n_out = 1'h0;
        // margin over the hold covers sync and debounce
        tick((hold_ms + 25) * MS_CYCLES);
        store_pad_n_out = 1'h1;
        // selects must outlive the debounced release
        tick(30 * MS_CYCLES);
        select_pad_a_n_out = 1'h1;
        select_pad_b_n_out = 1'h1;
        level_pad_out = LVL_39K;
        tick(5 * MS_CYCLES);
    endtask

    // one-cycle event: 0 any motion, 1 left, 2 right
    task automatic motion(input int sel);
        motion_out = (sel == 0);
        motion_left_out = (sel == 1);
        motion_right_out = (sel == 2);
        tick(1);
        motion_out = 1'h0;
        motion_left_out = 1'h0;
        motion_right_out = 1'h0;
    endtask
endmodule

// ### tb/pir_setting_program_output_tb.sv
// self-checking bench for the settings store and detect output stage
`timescale 1ns/1ns
`include "pir_settings_map.svh"
module pir_setting_program_output_tb;
    import pir_settings_pkg::*;
    localparam int MS = 5;
    typedef struct {logic pulse; sens_t sens; logic [3:0] dwell; mode_t mode; int len;} note_t;

    logic       clk_in, rst_in, pa_n, pb_n, st_n, mo, ml, mr, detect;
    level_t     lvl_pad, lvl;
    sens_t      sens, exp_s;
    logic [3:0] dwell;
    mode_t      mode, dm;
    int         d;
    int         failures = 0;
    int         n_compared = 0;
    note_t      notes[$];

    initial begin
        clk_in = 1'h0;
        forever #2 clk_in = ~clk_in;
    end

    pir_setting_program_output #(.MS_CYCLES(MS)) u_dut (
        .clk_in(clk_in), .rst_in(rst_in), .select_pad_a_n_in(pa_n),
        .select_pad_b_n_in(pb_n), .store_pad_n_in(st_n), .level_pad_in(lvl_pad),
        .motion_in(mo), .motion_left_in(ml), .motion_right_in(mr), .detect_out(detect),
        .sens_level_out(sens), .dwell_sel_out(dwell), .mode_out(mode));

    pad_operator #(.MS_CYCLES(MS)) u_op (
        .clk_in(clk_in), .select_pad_a_n_out(pa_n), .select_pad_b_n_out(pb_n),
        .store_pad_n_out(st_n), .level_pad_out(lvl_pad), .motion_out(mo),
        .motion_left_out(ml), .motion_right_out(mr));

    // ======================================================================
    // helpers
    task automatic mismatch(input string msg);
        failures++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask

    task automatic note(input logic p, input sens_t s, input logic [3:0] d, input mode_t m,
                        input int len);
        note_t n;
        n = '{p, s, d, m, len};
        notes.push_back(n);
    endtask

    task automatic check_set(input sens_t s, input logic [3:0] d, input mode_t m);
        n_compared++;
        if (sens !== s || dwell !== d || mode !== m) mismatch("settings differ");
    endtask

    // bounded wait for the output to drop
    task automatic wait_low(input int limit);
        for (int i = 0; i < limit && detect !== 1'h0; i++) @(posedge clk_in);
        u_op.tick(2);
    endtask

    function automatic sens_t sens_of(input level_t l);
        case (l)
            LVL_2K7: return SENS_MIN;
            LVL_6K8: return SENS_LOW;
            LVL_15K: return SENS_HIGH;
            LVL_39K: return SENS_MAX;
            default: return SENS_MED;
        endcase
    endfunction

    task automatic complete_run;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ======================================================================
    // monitor: any settings change or finished pulse consumes the oldest note
    initial begin : monitor
        logic [8:0] last;
        int         len;
        note_t      n;
        len = 0;
        @(negedge rst_in);
        @(posedge clk_in);
        last = {sens, dwell, mode};
        forever begin
            @(posedge clk_in);
            #1;
            if (detect === 1'h1) len++;
            if ((detect !== 1'h1 && len > 0) || {sens, dwell, mode} !== last) begin
                n_compared++;
                if (notes.size() == 0) mismatch("result without a note");
                else begin
                    n = notes.pop_front();
                    if (n.pulse && (len < n.len - MS - 2 || len > n.len + MS + 2))
                        mismatch("pulse length");
                    if (!n.pulse && {sens, dwell, mode} !== {n.sens, n.dwell, n.mode})
                        mismatch("stored settings");
                end
                if (detect !== 1'h1) len = 0;
                last = {sens, dwell, mode};
            end
        end
    end

    // watchdog sized above the roughly 51k cycles of stimulus
    initial begin
        #256000;
        mismatch("watchdog expired");
        complete_run;
    end

    // ======================================================================
    // main sequence
    initial begin
        void'($urandom(11));
        rst_in = 1'h1;
        repeat (6) @(posedge clk_in);
        #1 rst_in = 1'h0;
        u_op.tick(1);
        check_set(SENS_MED, `DWELL_DEFAULT, MODE_RETRIG);
        n_compared++;
        // no analogue front end to settle in this model, so detect is read at once
        if (detect !== 1'h0) mismatch("detect not idle");
        // released too early: nothing written, whatever the selects
        u_op.store(1'($urandom), 1'($urandom), LVL_39K, 500);
        check_set(SENS_MED, `DWELL_DEFAULT, MODE_RETRIG);
        lvl = level_t'(3'(1 + $urandom % 4));
        exp_s = sens_of(lvl);
        note(1'h0, exp_s, `DWELL_DEFAULT, MODE_RETRIG, 0);
        u_op.store(1'h1, 1'h1, lvl, 1000);
        note(1'h0, exp_s, `DWELL_IDX_0S3, MODE_RETRIG, 0);
        u_op.store(1'h0, 1'h1, LVL_2K7, 1000);
        // shortest dwell ignores a second event mid-pulse
        note(1'h1, exp_s, 4'h0, MODE_RETRIG, 300 * MS);
        u_op.motion(0);
        u_op.tick(150 * MS);
        u_op.motion(0);
        wait_low(400 * MS);
        // direction picked at random: 0 left, 1 right
        d = $urandom % 2;
        dm = d ? MODE_RIGHT : MODE_LEFT;
        note(1'h0, exp_s, `DWELL_IDX_0S3, dm, 0);
        u_op.store(1'h0, 1'h0, d ? LVL_39K : LVL_15K, 1000);
        u_op.motion(2 - d);
        u_op.tick(100);
        n_compared++;
        if (detect !== 1'h0) mismatch("wrong direction answered");
        note(1'h1, exp_s, 4'h0, dm, 200 * MS);
        u_op.motion(1 + d);
        wait_low(300 * MS);
        lvl = level_t'(3'($urandom % 5));
        note(1'h0, exp_s, 4'h5 + 4'(lvl), dm, 0);
        u_op.store(1'h1, 1'h0, lvl, 1000);
        note(1'h0, SENS_MED, `DWELL_DEFAULT, MODE_RETRIG, 0);
        u_op.store(1'h0, 1'h0, LVL_GND, 1000);
        // retrigger half way through stretches the pulse
        note(1'h1, SENS_MED, 4'h1, MODE_RETRIG, 1500 * MS);
        u_op.motion(0);
        u_op.tick(500 * MS);
        u_op.motion(0);
        wait_low(1200 * MS);
        // single pulse ignores a mid-pulse event, then an event in the quiet gap
        note(1'h0, SENS_MED, `DWELL_DEFAULT, MODE_SINGLE, 0);
        u_op.store(1'h0, 1'h0, LVL_6K8, 1000);
        note(1'h1, SENS_MED, `DWELL_DEFAULT, MODE_SINGLE, 1000 * MS);
        u_op.motion(0);
        u_op.tick(500 * MS);
        u_op.motion(0);
        wait_low(1200 * MS);
        u_op.tick(200 * MS);
        u_op.motion(0);
        u_op.tick(10);
        n_compared++;
        if (detect !== 1'h0) mismatch("quiet gap answered");
        n_compared++;
        if (notes.size() != 0) mismatch("results missing");
        complete_run;
    end
endmodule
